// ===== hdl/apb_keyed_watchdog_timer.sv
// keyed watchdog timer with an apb slave port
// assumes sys_clk drives the apb port, tmr_clk is a slow asynchronous pacing clock
`timescale 1ns/10ps
`default_nettype none
module apb_keyed_watchdog_timer #(
	parameter int DATA_W = 32, // bus data width, 16 or 32
	parameter int ADDR_W = 32 // bus address width, 16 or 32
) (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic tmr_clk,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [DATA_W-1:0] pwdata,
	input wire logic debugger_present,
	output logic clock_request,
	output logic pready,
	output logic [DATA_W-1:0] prdata,
	output logic pslverr,
	output logic timeout_irq_n
);
	// wide bus selects the single counter register
	localparam logic WIDE = (DATA_W == wdt_pkg::CNT_W);

	// decoded access
	logic [7:0] ofs; // low address byte
	wdt_pkg::reg_sel_e sel; // decoded register
	logic wr_acc; // write in its access phase
	logic rd_setup; // read in its setup phase
	logic rd_acc; // read in its access phase

	// register state
	logic [31:0] cnt_r; // watchdog counter
	logic [31:0] cnt_nxt; // counter next value
	logic [15:0] hi_buf_r; // high half buffer
	logic on_r; // watchdog_on
	logic halt_r; // halt_in_debug
	logic [DATA_W-1:0] rdata_r; // read data register
	logic irq_n_r; // timeout interrupt, active low

	// timer pacing
	logic tmr_level; // synchronised timer clock
	logic tmr_tick; // one pulse per timer clock rise
	logic dbg_level; // synchronised debugger flag
	logic halt_now; // counting stopped for the debugger
	logic cnt_zero; // counter at zero
	logic cnt_wr; // unlocked counter load this cycle
	logic ctrl_wr; // unlocked control write this cycle

	// carrier to the lock machine
	wdt_key_if kif ();

	// only the eight lsbs take part in the decode
	assign ofs = paddr[wdt_pkg::DEC_W-1:0];
	// offsets per bus width
	assign sel = wdt_pkg::decode(ofs, WIDE);

	// zero wait states, every transfer completes
	assign pready = 1'b1;
	// no errors are ever signalled
	assign pslverr = 1'b0;

	// phase qualifiers
	assign wr_acc = psel & penable & pwrite;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign rd_acc = psel & penable & ~pwrite;

	// drive the lock machine with mapped writes
	assign kif.wr_stb = wr_acc & (sel != wdt_pkg::SEL_NONE);
	assign kif.wr_sel = sel;
	assign kif.wr_key = pwdata[wdt_pkg::HALF_W-1:0];

	// key lock machine
	wdt_key_lock u_lock (
		.sys_clk(sys_clk),
		.srst(srst),
		.kif(kif)
	);

	// timer clock edges, sampled on sys_clk
	wdt_in_sync u_tmr_sync (
		.sys_clk(sys_clk),
		.srst(srst),
		.async_in(tmr_clk),
		.level(tmr_level),
		.rise(tmr_tick)
	);

	// debugger flag from outside the clock domain
	wdt_in_sync u_dbg_sync (
		.sys_clk(sys_clk),
		.srst(srst),
		.async_in(debugger_present),
		.level(dbg_level),
		.rise()
	);

	// guarded writes: locked writes leave contents unchanged
	assign cnt_wr = wr_acc & kif.unlocked & (sel == wdt_pkg::SEL_CNT_LO);
	assign ctrl_wr = wr_acc & kif.unlocked & (sel == wdt_pkg::SEL_CTRL);

	// debug halt applies only with halt_in_debug set
	assign halt_now = halt_r & dbg_level;
	assign cnt_zero = (cnt_r == wdt_pkg::CNT_RST);

	// ask for the timer clock while a decrement is pending
	assign clock_request = on_r & ~cnt_zero & ~halt_now;

	// counter next value: a load beats a decrement
	always_comb begin
		cnt_nxt = cnt_r;
		if (cnt_wr) begin
			if (WIDE) begin
				cnt_nxt = 32'(pwdata);
			end else begin
				cnt_nxt = {hi_buf_r, pwdata[wdt_pkg::HALF_W-1:0]};
			end
		end else if (on_r && !cnt_zero && !halt_now && tmr_tick) begin
			// one step per timer clock rise, halts at zero
			cnt_nxt = cnt_r - wdt_pkg::CNT_ONE;
		end
	end

	// counter register
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			cnt_r <= wdt_pkg::CNT_RST;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	// high half buffer: filled by a high write, or by a low read
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			hi_buf_r <= wdt_pkg::HALF_RST;
		end else if (!WIDE && wr_acc && kif.unlocked && sel == wdt_pkg::SEL_CNT_HI) begin
			// only the buffer changes, the counter waits for a low write
			hi_buf_r <= pwdata[wdt_pkg::HALF_W-1:0];
		end else if (!WIDE && rd_acc && sel == wdt_pkg::SEL_CNT_LO) begin
			// snapshot so a later high read matches this low read
			hi_buf_r <= cnt_r[wdt_pkg::CNT_W-1:wdt_pkg::HALF_W];
		end
	end

	// control register: enable and debug halt
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			// watchdog starts disabled
			on_r <= 1'b0;
			halt_r <= 1'b0;
		end else if (ctrl_wr) begin
			on_r <= pwdata[wdt_pkg::CTRL_ON_BIT];
			halt_r <= pwdata[wdt_pkg::CTRL_HALT_BIT];
		end
	end

	// read data, loaded in the setup phase so it stands in the access phase
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			rdata_r <= '0;
		end else if (rd_setup) begin
			unique case (sel)
				wdt_pkg::SEL_CNT_LO: begin
					if (WIDE) begin
						rdata_r <= DATA_W'(cnt_r);
					end else begin
						rdata_r <= DATA_W'(cnt_r[wdt_pkg::HALF_W-1:0]);
					end
				end
				// buffered upper half
				wdt_pkg::SEL_CNT_HI: rdata_r <= DATA_W'(hi_buf_r);
				// enable and halt bits, the rest read zero
				wdt_pkg::SEL_CTRL: rdata_r <= DATA_W'({halt_r, on_r});
				// write-only keys and unmapped offsets read zero
				default: rdata_r <= '0;
			endcase
		end
	end

	assign prdata = rdata_r;

	// timeout interrupt: enabled and counted out
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			irq_n_r <= 1'b1;
		end else begin
			irq_n_r <= ~(on_r & cnt_zero);
		end
	end

	assign timeout_irq_n = irq_n_r;

	// interrupt follows enable and zero count one cycle later
	a_irq_on_zero: assert property (@(posedge sys_clk) disable iff (srst)
		(on_r && cnt_zero) |=> !timeout_irq_n)
		else $error("timeout interrupt not raised at zero");
	a_irq_quiet: assert property (@(posedge sys_clk) disable iff (srst)
		!(on_r && cnt_zero) |=> timeout_irq_n)
		else $error("timeout interrupt raised without cause");

	// each timer tick takes exactly one off a running count
	a_count_step: assert property (@(posedge sys_clk) disable iff (srst)
		(tmr_tick && on_r && !cnt_zero && !halt_now && !cnt_wr) |=> cnt_r == $past(cnt_r) - wdt_pkg::CNT_ONE)
		else $error("counter did not decrement by one");

	// a zero count stays at zero until reloaded
	a_zero_holds: assert property (@(posedge sys_clk) disable iff (srst)
		(cnt_zero && !cnt_wr) |=> cnt_zero)
		else $error("counter moved below zero");

	// locked writes leave control untouched
	a_locked_ctrl: assert property (@(posedge sys_clk) disable iff (srst)
		(wr_acc && !kif.unlocked && sel == wdt_pkg::SEL_CTRL) |=> $stable(on_r) && $stable(halt_r))
		else $error("control changed while locked");

	// wide bus loads the whole counter
	a_full_load: assert property (@(posedge sys_clk) disable iff (srst)
		(WIDE && cnt_wr) |=> cnt_r == 32'($past(pwdata)))
		else $error("counter not loaded from write data");

	// narrow bus joins buffer and low data
	a_low_load: assert property (@(posedge sys_clk) disable iff (srst)
		(!WIDE && cnt_wr) |=> cnt_r == {$past(hi_buf_r), $past(pwdata[wdt_pkg::HALF_W-1:0])})
		else $error("counter not loaded from buffer and low data");

	// low read snapshots the high half
	a_hi_capture: assert property (@(posedge sys_clk) disable iff (srst)
		(!WIDE && rd_acc && sel == wdt_pkg::SEL_CNT_LO) |=> hi_buf_r == $past(cnt_r[wdt_pkg::CNT_W-1:wdt_pkg::HALF_W]))
		else $error("high half not captured on low read");

	// high write touches only the buffer
	a_hi_write: assert property (@(posedge sys_clk) disable iff (srst)
		(!WIDE && wr_acc && sel == wdt_pkg::SEL_CNT_HI && !tmr_tick) |=> $stable(cnt_r))
		else $error("counter changed on high half write");

	// debug halt freezes the count
	a_debug_halt: assert property (@(posedge sys_clk) disable iff (srst)
		(halt_r && dbg_level && !cnt_wr) |=> $stable(cnt_r))
		else $error("counter moved during debug halt");

	// enable bit lands from write data bit zero
	a_ctrl_enable: assert property (@(posedge sys_clk) disable iff (srst)
		ctrl_wr |=> on_r == $past(pwdata[wdt_pkg::CTRL_ON_BIT]))
		else $error("watchdog_on not taken from bit zero");

	// clock request tracks a pending decrement
	a_clk_request: assert property (@(posedge sys_clk) disable iff (srst)
		(on_r && !cnt_zero && !halt_now) |-> clock_request)
		else $error("clock request missing");

	// no clock request when nothing is left to count
	a_clk_stop: assert property (@(posedge sys_clk) disable iff (srst)
		(!on_r || cnt_zero || halt_now) |-> !clock_request)
		else $error("clock request without pending decrement");

	// debugger with halt_in_debug set drops the clock request
	a_dbg_request: assert property (@(posedge sys_clk) disable iff (srst)
		(halt_r && dbg_level) |-> !clock_request)
		else $error("clock requested during debug halt");

	// ready high and no error on every access
	a_no_wait: assert property (@(posedge sys_clk) disable iff (srst)
		(psel && penable) |-> (pready && !pslverr))
		else $error("transfer stalled or errored");

	// disabled straight after reset
	a_reset_off: assert property (@(posedge sys_clk) disable iff (srst)
		$past(srst) |-> (!on_r && !halt_r && timeout_irq_n))
		else $error("watchdog enabled after reset");

	// counter and high buffer start cleared
	a_reset_count: assert property (@(posedge sys_clk) disable iff (srst)
		$past(srst) |-> (cnt_zero && hi_buf_r == wdt_pkg::HALF_RST))
		else $error("counter or buffer not cleared by reset");

	// debug halt bit lands from write data bit one
	a_ctrl_halt: assert property (@(posedge sys_clk) disable iff (srst)
		ctrl_wr |=> halt_r == $past(pwdata[wdt_pkg::CTRL_HALT_BIT]))
		else $error("halt_in_debug not taken from bit one");

	// locked counter writes leave the count alone apart from ticks
	a_locked_cnt: assert property (@(posedge sys_clk) disable iff (srst)
		(wr_acc && !kif.unlocked && sel == wdt_pkg::SEL_CNT_LO && !tmr_tick) |=> $stable(cnt_r))
		else $error("counter changed on a locked write");

	// locked high-half writes leave the buffer alone
	a_locked_hi: assert property (@(posedge sys_clk) disable iff (srst)
		(!WIDE && wr_acc && !kif.unlocked && sel == wdt_pkg::SEL_CNT_HI) |=> $stable(hi_buf_r))
		else $error("high buffer changed on a locked write");

	// control read returns both control bits
	a_rd_ctrl: assert property (@(posedge sys_clk) disable iff (srst)
		(rd_setup && sel == wdt_pkg::SEL_CTRL) |=> prdata == DATA_W'({$past(halt_r), $past(on_r)}))
		else $error("control read data wrong");

	// high-half read returns the buffer
	a_rd_hi: assert property (@(posedge sys_clk) disable iff (srst)
		(!WIDE && rd_setup && sel == wdt_pkg::SEL_CNT_HI) |=> prdata == DATA_W'($past(hi_buf_r)))
		else $error("high half read data wrong");

	// wide bus reads the whole counter
	a_rd_full: assert property (@(posedge sys_clk) disable iff (srst)
		(WIDE && rd_setup && sel == wdt_pkg::SEL_CNT_LO) |=> prdata == DATA_W'($past(cnt_r)))
		else $error("counter read data wrong");

	// key ports are write only and read zero
	a_rd_keys: assert property (@(posedge sys_clk) disable iff (srst)
		(rd_setup && (sel == wdt_pkg::SEL_KEY_A || sel == wdt_pkg::SEL_KEY_B)) |=> prdata == '0)
		else $error("key port read not zero");

	// wide bus has no high-half register
	a_wide_no_hi: assert property (@(posedge sys_clk) disable iff (srst)
		WIDE |-> sel != wdt_pkg::SEL_CNT_HI)
		else $error("high half decoded on wide bus");

	// disabled watchdog does not count
	a_off_no_count: assert property (@(posedge sys_clk) disable iff (srst)
		(!on_r && !cnt_wr) |=> $stable(cnt_r))
		else $error("counter moved while disabled");

	// disabled watchdog keeps the interrupt quiet
	a_irq_off: assert property (@(posedge sys_clk) disable iff (srst)
		!on_r |=> timeout_irq_n)
		else $error("interrupt raised while disabled");

	// without a timer tick the count only moves by a load
	a_no_tick_hold: assert property (@(posedge sys_clk) disable iff (srst)
		(!tmr_tick && !cnt_wr) |=> $stable(cnt_r))
		else $error("counter moved without a timer tick");

	// read data stands until the next read setup phase
	a_rdata_hold: assert property (@(posedge sys_clk) disable iff (srst)
		!rd_setup |=> $stable(prdata))
		else $error("read data changed outside a read setup");
endmodule
`default_nettype wire

// ===== hdl/wdt_in_sync.sv
// three-stage synchroniser for one level from outside sys_clk, with rise pulse
// assumes the input may change at any time relative to sys_clk
`timescale 1ns/10ps
`default_nettype none
module wdt_in_sync (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic async_in,
	output logic level,
	output logic rise
);
	logic s1_r; // first stage, read only by s2_r
	logic s2_r; // second stage
	logic s3_r; // third stage
	logic level_r; // accepted level

	// shift chain
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
		end else begin
			s1_r <= async_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// accept a change once stages two and three agree
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			level_r <= 1'b0;
		end else if (s2_r == s3_r) begin
			level_r <= s3_r;
		end
	end

	assign level = level_r;
	assign rise = s2_r & s3_r & ~level_r;
endmodule
`default_nettype wire

// ===== hdl/wdt_key_if.sv
// carrier between the register decoder and the key lock machine
// assumes both ends run on sys_clk
`timescale 1ns/10ps
`default_nettype none
interface wdt_key_if;
	logic wr_stb; // one-cycle write strobe of a decoded register
	wdt_pkg::reg_sel_e wr_sel; // register being written
	logic [15:0] wr_key; // low half of the write data
	logic unlocked; // lock machine is open
	modport regs (output wr_stb, output wr_sel, output wr_key, input unlocked);
	modport lock (input wr_stb, input wr_sel, input wr_key, output unlocked);
endinterface
`default_nettype wire

// ===== hdl/wdt_key_lock.sv
// key lock machine guarding counter and control writes
// assumes write strobes come from the register decoder on sys_clk
`timescale 1ns/10ps
`default_nettype none
module wdt_key_lock (
	input wire logic sys_clk,
	input wire logic srst,
	wdt_key_if.lock kif
);
	wdt_pkg::lock_e st_r; // current lock state
	wdt_pkg::lock_e st_nxt; // next lock state

	// next state on each register write
	always_comb begin
		st_nxt = st_r;
		if (kif.wr_stb) begin
			st_nxt = wdt_pkg::LK_LOCKED; // any other write breaks the sequence
			unique case (st_r)
				wdt_pkg::LK_LOCKED: begin
					if (kif.wr_sel == wdt_pkg::SEL_KEY_A && kif.wr_key == wdt_pkg::KEY_FIRST) begin
						st_nxt = wdt_pkg::LK_GOT_A;
					end
				end
				wdt_pkg::LK_GOT_A: begin
					if (kif.wr_sel == wdt_pkg::SEL_KEY_B && kif.wr_key == wdt_pkg::KEY_SECOND) begin
						st_nxt = wdt_pkg::LK_GOT_AB;
					end
				end
				wdt_pkg::LK_GOT_AB: begin
					if (kif.wr_sel == wdt_pkg::SEL_KEY_A && kif.wr_key == wdt_pkg::KEY_THIRD) begin
						st_nxt = wdt_pkg::LK_OPEN;
					end
				end
				wdt_pkg::LK_OPEN: st_nxt = wdt_pkg::LK_LOCKED;
			endcase
		end
	end

	// state register, locked after reset
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			st_r <= wdt_pkg::LK_LOCKED;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign kif.unlocked = (st_r == wdt_pkg::LK_OPEN);

	a_lock_at_reset: assert property (@(posedge sys_clk) disable iff (srst) $past(srst) |-> !kif.unlocked)
		else $error("lock machine not locked after reset");
	a_key_sequence: assert property (@(posedge sys_clk) disable iff (srst)
		(st_r == wdt_pkg::LK_GOT_AB && kif.wr_stb && kif.wr_sel == wdt_pkg::SEL_KEY_A
		&& kif.wr_key == wdt_pkg::KEY_THIRD) |=> kif.unlocked)
		else $error("third key did not unlock");
	a_seq_abandon: assert property (@(posedge sys_clk) disable iff (srst)
		(st_r == wdt_pkg::LK_GOT_A && kif.wr_stb && kif.wr_sel != wdt_pkg::SEL_KEY_B)
		|=> st_r == wdt_pkg::LK_LOCKED ##1 !kif.unlocked)
		else $error("key sequence not abandoned");
	a_write_relocks: assert property (@(posedge sys_clk) disable iff (srst)
		(kif.unlocked && kif.wr_stb) |=> !kif.unlocked)
		else $error("write while unlocked did not relock");
endmodule
`default_nettype wire

// ===== hdl/wdt_pkg.sv
// constants, types and the register decoder shared by the keyed watchdog
// assumes one clock sys_clk, a synchronous active-high reset and an apb-style slave port
//
// Functional notes
// - irq low while enabled and count is zero
// - enabled watchdog counts down, stops at zero
// - lock machine starts locked after reset
// - unlock: 1234 key a, 5665 key b, 4321 key a
// - other register write abandons key sequence
// - any mapped register write while unlocked relocks
// - counter and control writes only while unlocked
// - 32-bit bus: whole counter at offset zero
// - low-half write loads low data, high buffer
// - low-half read captures high half into buffer
// - high-half write only fills the buffer
// - 16-bit map: 00, 02, 04, 08, 0c
// - 32-bit map: 00, 04, 08, 0c
// - only eight address lsbs decoded
// - control bit 0 enables the watchdog
// - control bit 1 halts counting under debugger
// - countdown paced by the timer clock
// - bus data and address width 16 or 32
package wdt_pkg;
	localparam int HALF_W = 16; // width of one counter half
	localparam int CNT_W = 32; // width of the counter
	localparam int DEC_W = 8; // decoded address lsbs
	localparam logic [7:0] OFS_CNT_LO = 8'h00; // counter, or its low half
	localparam logic [7:0] OFS_CNT_HI = 8'h02; // high half, narrow bus only
	localparam logic [7:0] OFS_CTRL = 8'h04; // control
	localparam logic [7:0] OFS_KEY_A = 8'h08; // first key port
	localparam logic [7:0] OFS_KEY_B = 8'h0c; // second key port
	localparam logic [15:0] KEY_FIRST = 16'h1234; // first key, port a
	localparam logic [15:0] KEY_SECOND = 16'h5665; // second key, port b
	localparam logic [15:0] KEY_THIRD = 16'h4321; // third key, port a
	localparam int CTRL_ON_BIT = 0; // watchdog_on
	localparam int CTRL_HALT_BIT = 1; // halt_in_debug
	localparam logic [31:0] CNT_RST = 32'h0000_0000; // counter after reset
	localparam logic [31:0] CNT_ONE = 32'h0000_0001; // decrement step
	localparam logic [15:0] HALF_RST = 16'h0000; // high buffer after reset

	// register selected by an access
	typedef enum logic [2:0] {SEL_NONE, SEL_CNT_LO, SEL_CNT_HI, SEL_CTRL, SEL_KEY_A, SEL_KEY_B} reg_sel_e;
	// lock machine states
	typedef enum logic [1:0] {LK_LOCKED, LK_GOT_A, LK_GOT_AB, LK_OPEN} lock_e;

	// decode the low address byte for the bus width in use
	function automatic reg_sel_e decode(input logic [7:0] ofs, input logic wide);
		reg_sel_e s;
		s = SEL_NONE;
		unique case (ofs)
			OFS_CNT_LO: s = SEL_CNT_LO;
			OFS_CNT_HI: s = wide ? SEL_NONE : SEL_CNT_HI;
			OFS_CTRL: s = SEL_CTRL;
			OFS_KEY_A: s = SEL_KEY_A;
			OFS_KEY_B: s = SEL_KEY_B;
			default: s = SEL_NONE;
		endcase
		return s;
	endfunction
endpackage

// ===== tb/apb_keyed_watchdog_timer_test.sv
// self-checking bench for the keyed watchdog, 32-bit and 16-bit bus and address
// assumes the package is compiled first and wdt_tmr_source paces the timer clock
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin error_cnt++; $display("Error at %0t: got %h expected %h", $time, (got), (exp)); end end
module apb_keyed_watchdog_timer_test;
	logic sys_clk = 1'b0; // 40 MHz block clock
	logic srst = 1'b1; // held for 16 cycles
	logic tmr_clk; // from the clock controller model
	logic psel = 1'b0; // apb select
	logic penable = 1'b0; // apb access phase
	logic pwrite = 1'b0; // apb direction
	logic debugger_present = 1'b0; // debug halt request
	logic [31:0] paddr = 32'h0000_0000; // apb address
	logic [31:0] pwdata = 32'h0000_0000; // apb write data
	logic [31:0] prdata; // apb read data
	logic clock_request; // timer clock wanted
	logic pready; // apb ready
	logic pslverr; // apb error
	logic timeout_irq_n; // active-low timeout
	int error_cnt = 0; // mismatches
	int n_checks = 0; // comparisons made
	int seed = 89; // fixed random seed
	logic [31:0] rd_v; // scratch read value
	logic [31:0] val; // value under test
	logic [15:0] rd_h; // read value of the narrow instance
	logic [15:0] prdata_h; // narrow apb read data
	logic creq_h; // narrow clock request
	logic pready_h; // narrow apb ready
	logic pslverr_h; // narrow apb error
	logic irq_h_n; // narrow active-low timeout

	// free-running block clock
	always #12.5 sys_clk = ~sys_clk;

	apb_keyed_watchdog_timer #(.DATA_W(32), .ADDR_W(32)) dut_u (
		.sys_clk(sys_clk), .srst(srst), .tmr_clk(tmr_clk), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .debugger_present(debugger_present),
		.clock_request(clock_request), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.timeout_irq_n(timeout_irq_n)
	);

	wdt_tmr_source tsrc_u (.clock_request(clock_request), .tmr_clk(tmr_clk));

	// 16-bit configuration on the same bus, for the buffered halves
	apb_keyed_watchdog_timer #(.DATA_W(16), .ADDR_W(16)) half_u (
		.sys_clk(sys_clk), .srst(srst), .tmr_clk(tmr_clk), .paddr(paddr[15:0]), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata[15:0]), .debugger_present(debugger_present),
		.clock_request(creq_h), .pready(pready_h), .prdata(prdata_h), .pslverr(pslverr_h),
		.timeout_irq_n(irq_h_n)
	);

	// expected control read-back: halt in bit 1, enable in bit 0
	function automatic logic [31:0] ctrl_word(input logic on, input logic halt);
		return {30'h0000_0000, halt, on};
	endfunction

	// one apb transfer; upper address bits are random and must not matter
	task automatic xfer(input logic wr, input logic [7:0] ofs, input logic [31:0] wd, output logic [31:0] rd);
		logic [31:0] hi;
		hi = $random(seed);
		@(negedge sys_clk);
		psel = 1'b1;
		penable = 1'b0;
		pwrite = wr;
		paddr = {hi[31:8], ofs};
		pwdata = wd;
		@(negedge sys_clk);
		penable = 1'b1;
		@(posedge sys_clk);
		rd = prdata;
		rd_h = prdata_h;
		`CHK(pready, 1'b1)
		`CHK(pslverr, 1'b0)
		`CHK(pready_h, 1'b1)
		`CHK(pslverr_h, 1'b0)
		@(negedge sys_clk);
		psel = 1'b0;
		penable = 1'b0;
	endtask

	// register write
	task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
		logic [31:0] dummy;
		xfer(1'b1, ofs, d, dummy);
	endtask

	// register read
	task automatic rd(input logic [7:0] ofs, output logic [31:0] d);
		xfer(1'b0, ofs, 32'h0000_0000, d);
	endtask

	// three-write key sequence
	task automatic unlock();
		wr(wdt_pkg::OFS_KEY_A, {16'h0000, wdt_pkg::KEY_FIRST});
		wr(wdt_pkg::OFS_KEY_B, {16'h0000, wdt_pkg::KEY_SECOND});
		wr(wdt_pkg::OFS_KEY_A, {16'h0000, wdt_pkg::KEY_THIRD});
	endtask

	// bounded wait for the interrupt line to reach a level
	task automatic wait_irq(input logic lvl, input int bound);
		int i;
		for (i = 0; i < bound; i++) begin
			@(negedge sys_clk);
			if (timeout_irq_n === lvl) begin
				return;
			end
		end
		error_cnt++;
		$display("Error at %0t: interrupt wait ran out, got %h expected %h", $time, timeout_irq_n, lvl);
		end_sim();
	endtask

	// verdict and end of run
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// main sequence
	initial begin
		repeat (16) @(posedge sys_clk);
		@(negedge sys_clk);
		srst = 1'b0;
		// state straight after reset, locked writes refused
		`CHK(timeout_irq_n, 1'b1)
		`CHK(clock_request, 1'b0)
		rd(wdt_pkg::OFS_CTRL, rd_v);
		`CHK(rd_v, ctrl_word(1'b0, 1'b0))
		wr(wdt_pkg::OFS_CNT_LO, 32'h0000_0055);
		rd(wdt_pkg::OFS_CNT_LO, rd_v);
		`CHK(rd_v, 32'h0000_0000)
		$display("test reset_and_lock done");
		// random loads through the full-width counter, then relock
		for (int k = 0; k < 6; k++) begin
			val = $random(seed);
			if (k == 0) begin
				val = 32'hffff_ffff;
			end
			unlock();
			wr(wdt_pkg::OFS_CNT_LO, val);
			rd(wdt_pkg::OFS_CNT_LO, rd_v);
			`CHK(rd_v, val)
			wr(wdt_pkg::OFS_CNT_LO, ~val);
			rd(wdt_pkg::OFS_CNT_LO, rd_v);
			`CHK(rd_v, val)
			`CHK(clock_request, 1'b0)
		end
		$display("test load_and_relock done");
		// interrupted and wrong key sequences leave the lock shut
		wr(wdt_pkg::OFS_KEY_A, {16'h0000, wdt_pkg::KEY_FIRST});
		wr(wdt_pkg::OFS_CTRL, ctrl_word(1'b1, 1'b0));
		wr(wdt_pkg::OFS_KEY_B, {16'h0000, wdt_pkg::KEY_SECOND});
		wr(wdt_pkg::OFS_KEY_A, {16'h0000, wdt_pkg::KEY_THIRD});
		wr(wdt_pkg::OFS_CNT_LO, 32'h0000_0077);
		rd(wdt_pkg::OFS_CNT_LO, rd_v);
		`CHK(rd_v, val)
		rd(wdt_pkg::OFS_CTRL, rd_v);
		`CHK(rd_v, ctrl_word(1'b0, 1'b0))
		wr(wdt_pkg::OFS_KEY_A, {16'h0000, wdt_pkg::KEY_FIRST});
		wr(wdt_pkg::OFS_KEY_B, 32'h0000_0000);
		wr(wdt_pkg::OFS_KEY_A, {16'h0000, wdt_pkg::KEY_THIRD});
		wr(wdt_pkg::OFS_CNT_LO, 32'h0000_0077);
		rd(wdt_pkg::OFS_CNT_LO, rd_v);
		`CHK(rd_v, val)
		rd(wdt_pkg::OFS_CNT_HI, rd_v);
		`CHK(rd_v, 32'h0000_0000)
		$display("test broken_keys done");
		// enabled countdown to zero raises the interrupt
		unlock();
		wr(wdt_pkg::OFS_CNT_LO, 32'h0000_0005);
		unlock();
		wr(wdt_pkg::OFS_CTRL, ctrl_word(1'b1, 1'b0));
		`CHK(clock_request, 1'b1)
		rd(wdt_pkg::OFS_CTRL, rd_v);
		`CHK(rd_v, ctrl_word(1'b1, 1'b0))
		wait_irq(1'b0, 400);
		rd(wdt_pkg::OFS_CNT_LO, rd_v);
		`CHK(rd_v, 32'h0000_0000)
		`CHK(clock_request, 1'b0)
		`CHK(timeout_irq_n, 1'b0)
		unlock();
		wr(wdt_pkg::OFS_CTRL, ctrl_word(1'b0, 1'b0));
		wait_irq(1'b1, 4);
		$display("test countdown done");
		// debug halt freezes the count until the debugger leaves
		debugger_present = 1'b1;
		unlock();
		wr(wdt_pkg::OFS_CNT_LO, 32'h0000_0003);
		unlock();
		wr(wdt_pkg::OFS_CTRL, ctrl_word(1'b1, 1'b1));
		repeat (80) @(negedge sys_clk);
		`CHK(clock_request, 1'b0)
		`CHK(timeout_irq_n, 1'b1)
		rd(wdt_pkg::OFS_CNT_LO, rd_v);
		`CHK(rd_v, 32'h0000_0003)
		debugger_present = 1'b0;
		wait_irq(1'b0, 300);
		$display("test debug_halt done");
		// narrow bus: buffered high half, low write loads both halves
		unlock();
		wr(wdt_pkg::OFS_CTRL, ctrl_word(1'b0, 1'b0));
		unlock();
		wr(wdt_pkg::OFS_CNT_HI, 32'h0000_a5c3);
		unlock();
		wr(wdt_pkg::OFS_CNT_LO, 32'h0000_1e0f);
		rd(wdt_pkg::OFS_CNT_LO, rd_v);
		`CHK(rd_h, 16'h1e0f)
		rd(wdt_pkg::OFS_CNT_HI, rd_v);
		`CHK(rd_h, 16'ha5c3)
		unlock();
		wr(wdt_pkg::OFS_CNT_HI, 32'h0000_0001);
		rd(wdt_pkg::OFS_CNT_LO, rd_v);
		`CHK(rd_h, 16'h1e0f)
		rd(wdt_pkg::OFS_CNT_HI, rd_v);
		`CHK(rd_h, 16'ha5c3)
		$display("test narrow_bus done");
		end_sim();
	end
endmodule
`default_nettype wire

// ===== tb/wdt_tmr_source.sv
// timer clock source standing in for the system clock controller
// assumes clock_request comes straight from the watchdog and the bench runs in ns
`timescale 1ns/10ps
`default_nettype none
module wdt_tmr_source (
	input wire logic clock_request,
	output logic tmr_clk
);
	// 200 ns period while requested, parked low otherwise
	// the odd start offset keeps every edge clear of the sys_clk edges
	initial begin
		tmr_clk = 1'b0;
		#7.3;
		forever begin
			#100;
			// toggle only while requested, park low otherwise
			tmr_clk = (clock_request === 1'b1) ? ~tmr_clk : 1'b0;
		end
	end
endmodule
`default_nettype wire
